// ==== stmr_regs.sv ====
// Threshold, parameter and command mailbox registers with wake control
`timescale 1ns/10ps
`default_nettype none
`include "stmr_cfg.svh"

module stmr_regs
  import stmr_pkg::*;
(
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  // Register access from the serial slave
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  // Sequencer handshake
  output logic            o_cmd_strobe,
  output logic      [7:0] o_cmd_code,
  output logic      [7:0] o_param_value,
  input  wire logic       i_cmd_done,
  input  wire logic       i_cmd_error,
  input  wire logic [7:0] i_err_code,
  input  wire logic       i_seq_sleep,
  // Proximity channel three measurements
  input  wire logic       i_autonomous,
  input  wire logic       i_ps3_valid,
  input  wire logic [15:0] i_ps3_result,
  output logic      [15:0] o_ch3_threshold,
  // Configuration
  input  wire logic       i_legacy_rev,
  input  wire logic [5:0] i_irq_enable,
  // Status outputs
  output logic            o_int,
  output logic            o_standby
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Address match, shared by write and read decoding
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] off);
    addr_is = (addr == off);
  endfunction : addr_is

  // Expand the 8-bit compressed threshold of older revisions
  function automatic stmr_word_t expand_thr(input stmr_byte_t c);
    logic [3:0] e;
    stmr_word_t base;
    e    = c[`STMR_EXP_HI:`STMR_EXP_LO];
    base = {`STMR_PAD_EXP, 1'b1, c[`STMR_MANT_HI:`STMR_MANT_LO]};
    if (e == `STMR_EXP_ZERO) begin
      expand_thr = {`STMR_PAD_PLAIN, c[`STMR_MANT_HI:`STMR_MANT_LO]};
    end else begin
      expand_thr = base << (e - `STMR_EXP_ONE);
    end
  endfunction : expand_thr

  // ----------------------------------------------------------------------
  // Revision strap synchroniser
  // ----------------------------------------------------------------------

  logic       legacy_meta;
  logic       legacy_sync;
  logic       next_legacy_meta;
  logic       next_legacy_sync;

  // The strap is a pin, so it passes two flops before anything reads it
  always_comb begin
    next_legacy_meta = i_legacy_rev;
    next_legacy_sync = legacy_meta;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      legacy_meta <= 1'b0;
      legacy_sync <= 1'b0;
    end else begin
      legacy_meta <= next_legacy_meta;
      legacy_sync <= next_legacy_sync;
    end
  end

  // ----------------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------------

  logic wr_th_low;
  logic wr_th_high;
  logic wr_param;
  logic wr_cmd;
  logic wr_resp;
  logic wr_irq;

  // One-hot write strobes per register
  assign wr_th_low  = i_reg_wr && addr_is(i_reg_addr, `STMR_ADDR_TH_LOW);
  assign wr_th_high = i_reg_wr && addr_is(i_reg_addr, `STMR_ADDR_TH_HIGH);
  assign wr_param   = i_reg_wr && addr_is(i_reg_addr, `STMR_ADDR_PARAM);
  assign wr_cmd     = i_reg_wr && addr_is(i_reg_addr, `STMR_ADDR_CMD);
  assign wr_resp    = i_reg_wr && addr_is(i_reg_addr, `STMR_ADDR_RESP);
  assign wr_irq     = i_reg_wr && addr_is(i_reg_addr, `STMR_ADDR_IRQ_STAT);

  // ----------------------------------------------------------------------
  // Host registers
  // ----------------------------------------------------------------------

  stmr_byte_t th_low;
  stmr_byte_t th_high;
  stmr_byte_t param_mbox;
  stmr_byte_t cmd_mbox;
  stmr_byte_t next_th_low;
  stmr_byte_t next_th_high;
  stmr_byte_t next_param_mbox;
  stmr_byte_t next_cmd_mbox;

  // Each byte lands on its own write; no shadow pairs the two halves,
  // which keeps the bank small but lets a half-updated value be seen
  always_comb begin
    next_th_low     = wr_th_low  ? i_reg_wdata : th_low;
    next_th_high    = wr_th_high ? i_reg_wdata : th_high;
    next_param_mbox = wr_param   ? i_reg_wdata : param_mbox;
    next_cmd_mbox   = wr_cmd     ? i_reg_wdata : cmd_mbox;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      th_low     <= `STMR_RST_BYTE;
      th_high    <= `STMR_RST_BYTE;
      param_mbox <= `STMR_RST_BYTE;
      cmd_mbox   <= `STMR_RST_BYTE;
    end else begin
      th_low     <= next_th_low;
      th_high    <= next_th_high;
      param_mbox <= next_param_mbox;
      cmd_mbox   <= next_cmd_mbox;
    end
  end

  // ----------------------------------------------------------------------
  // Threshold compare
  // ----------------------------------------------------------------------

  stmr_word_t eff_thr;
  logic       ps3_hit;

  // Live register bytes are used, so a compare between the two byte
  // writes sees a mixed threshold; software must pause measurements
  always_comb begin
    if (legacy_sync) begin
      eff_thr = expand_thr(th_low);
    end else begin
      eff_thr = {th_high, th_low};
    end
    ps3_hit = i_autonomous && i_ps3_valid && (i_ps3_result > eff_thr);
  end

  // ----------------------------------------------------------------------
  // Response counter and interrupt status
  // ----------------------------------------------------------------------

  stmr_byte_t             response;
  logic [`STMR_IRQ_W-1:0] irq_status;
  stmr_byte_t             next_response;
  logic [`STMR_IRQ_W-1:0] next_irq_status;
  logic [`STMR_IRQ_W-1:0] irq_set;

  // A finished command bumps the wrapping count or loads an error code;
  // the sequencer event wins over a host write in the same cycle
  always_comb begin
    next_response = response;
    if (i_cmd_done) begin
      if (i_cmd_error) begin
        next_response = i_err_code;
      end else begin
        next_response = {`STMR_RST_NIB,
                         response[`STMR_CNT_HI:0] + `STMR_CNT_ONE};
      end
    end else if (wr_resp) begin
      next_response = i_reg_wdata;
    end
  end

  // Hardware set beats a write-one clear arriving in the same cycle
  always_comb begin
    irq_set                = `STMR_IRQ_ZERO;
    irq_set[`STMR_IRQ_CMD] = i_cmd_done;
    irq_set[`STMR_IRQ_PS3] = ps3_hit;
    next_irq_status        = irq_status;
    for (int b = 0; b < `STMR_IRQ_W; b++) begin
      if (irq_set[b]) begin
        next_irq_status[b] = 1'b1;
      end else if (wr_irq && i_reg_wdata[b]) begin
        next_irq_status[b] = 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      response   <= `STMR_RST_BYTE;
      irq_status <= `STMR_IRQ_ZERO;
    end else begin
      response   <= next_response;
      irq_status <= next_irq_status;
    end
  end

  // ----------------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------------

  stmr_pwr_t pwr_state;
  stmr_pwr_t next_pwr_state;

  // Only a command write wakes; reads and other writes are ignored here
  always_comb begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      STMR_PWR_STANDBY: begin
        if (wr_cmd) begin
          next_pwr_state = STMR_PWR_AWAKE;
        end
      end
      STMR_PWR_AWAKE: begin
        if (i_seq_sleep && !wr_cmd) begin
          next_pwr_state = STMR_PWR_STANDBY;
        end
      end
      default: begin
        next_pwr_state = STMR_PWR_STANDBY;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pwr_state <= STMR_PWR_STANDBY;
    end else begin
      pwr_state <= next_pwr_state;
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------

  stmr_byte_t next_rdata;
  logic       next_int;

  // Read data; unmapped offsets and reserved bits return zero
  always_comb begin
    next_rdata = `STMR_RST_BYTE;
    if (!i_reg_rd) begin
      next_rdata = `STMR_RST_BYTE;
    end else if (addr_is(i_reg_addr, `STMR_ADDR_TH_LOW)) begin
      next_rdata = th_low;
    end else if (addr_is(i_reg_addr, `STMR_ADDR_TH_HIGH)) begin
      next_rdata = th_high;
    end else if (addr_is(i_reg_addr, `STMR_ADDR_PARAM)) begin
      next_rdata = param_mbox;
    end else if (addr_is(i_reg_addr, `STMR_ADDR_CMD)) begin
      next_rdata = cmd_mbox;
    end else if (addr_is(i_reg_addr, `STMR_ADDR_RESP)) begin
      next_rdata = response;
    end else if (addr_is(i_reg_addr, `STMR_ADDR_IRQ_STAT)) begin
      next_rdata = {`STMR_RSVD_ZERO, irq_status};
    end
    next_int = |(next_irq_status & i_irq_enable);
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata     <= `STMR_RST_BYTE;
      o_cmd_strobe    <= 1'b0;
      o_cmd_code      <= `STMR_RST_BYTE;
      o_param_value   <= `STMR_RST_BYTE;
      o_ch3_threshold <= `STMR_RST_WORD;
      o_int           <= 1'b0;
      o_standby       <= 1'b1;
    end else begin
      o_reg_rdata     <= next_rdata;
      o_cmd_strobe    <= wr_cmd;
      o_cmd_code      <= next_cmd_mbox;
      o_param_value   <= next_param_mbox;
      o_ch3_threshold <= eff_thr;
      o_int           <= next_int;
      o_standby       <= (next_pwr_state == STMR_PWR_STANDBY);
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------

  chk_low_byte_store: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    wr_th_low |=> (th_low == $past(i_reg_wdata)))
    else $error("low threshold byte not stored");

  chk_high_byte_alone: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (wr_th_high && !wr_th_low) |=> (th_high == $past(i_reg_wdata))
                                   && (th_low == $past(th_low)))
    else $error("high threshold byte write disturbed the other byte");

  chk_param_mailbox: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    wr_param |=> (o_param_value == $past(i_reg_wdata)))
    else $error("parameter mailbox value not presented");

  chk_cmd_presented: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    wr_cmd |=> o_cmd_strobe && (o_cmd_code == $past(i_reg_wdata)))
    else $error("command not presented to sequencer");

  chk_wake_cause: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    $fell(o_standby) |-> $past(wr_cmd))
    else $error("left standby without a command write");

  chk_stay_standby: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (o_standby && !wr_cmd) |=> o_standby)
    else $error("left standby on another access");

  chk_resp_count: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (i_cmd_done && !i_cmd_error) |=>
      (response[`STMR_CNT_HI:0] == $past(response[`STMR_CNT_HI:0]) + `STMR_CNT_ONE))
    else $error("response counter did not advance");

  chk_ps3_compare: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    ps3_hit |=> irq_status[`STMR_IRQ_PS3] && (o_int || !$past(i_irq_enable[`STMR_IRQ_PS3])))
    else $error("threshold crossing did not raise status");

  chk_int_level: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    ##1 (o_int == |(irq_status & $past(i_irq_enable))))
    else $error("interrupt output disagrees with status and enable");

  chk_legacy_thr: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    legacy_sync |=> (o_ch3_threshold == expand_thr($past(th_low))))
    else $error("compressed threshold not used on older revision");

  chk_reset_zero: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    $fell(i_rst) |-> (th_low == `STMR_RST_BYTE) && (cmd_mbox == `STMR_RST_BYTE))
    else $error("registers not zero after reset");

endmodule : stmr_regs
`default_nettype wire

// ==== stmr_cfg.svh ====
// Constants for the threshold and mailbox register bank
// Function
// - 16-bit channel three threshold at 0x15/0x16
// - Compare each autonomous result against threshold
// - No protection; mixed byte threshold possible
// - Older revisions: 8-bit compressed threshold 0x15
// - All four registers clear to zero
// - Parameter mailbox, 8-bit RW at 0x17
// - Command mailbox 0x18 write presents command
// - Only command write leaves standby
// - Error-free done increments response counter 3:0
// - Interrupt when status and enable set
`ifndef STMR_CFG_SVH
`define STMR_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define STMR_ADDR_TH_LOW   8'h15
`define STMR_ADDR_TH_HIGH  8'h16
`define STMR_ADDR_PARAM    8'h17
`define STMR_ADDR_CMD      8'h18
`define STMR_ADDR_RESP     8'h20
`define STMR_ADDR_IRQ_STAT 8'h21

// ----------------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------------
`define STMR_RST_BYTE      8'h00
`define STMR_RST_WORD      16'h0000
`define STMR_RST_NIB       4'h0
`define STMR_CNT_ONE       4'h1
`define STMR_CNT_HI        3
`define STMR_ERR_BIT       7
`define STMR_IRQ_W         6
`define STMR_IRQ_ZERO      6'h00
`define STMR_IRQ_CMD       5
`define STMR_IRQ_PS3       4
`define STMR_RSVD_ZERO     2'h0

// ----------------------------------------------------------------------
// Compressed threshold layout: upper nibble exponent, lower mantissa
// ----------------------------------------------------------------------
`define STMR_EXP_HI        7
`define STMR_EXP_LO        4
`define STMR_MANT_HI       3
`define STMR_MANT_LO       0
`define STMR_EXP_ZERO      4'h0
`define STMR_EXP_ONE       4'h1
`define STMR_PAD_EXP       11'h000
`define STMR_PAD_PLAIN     12'h000

`endif

// ==== stmr_pkg.sv ====
// Types shared by the threshold and mailbox register bank
`default_nettype none
package stmr_pkg;

  // Power state of the device
  typedef enum logic {
    STMR_PWR_STANDBY,
    STMR_PWR_AWAKE
  } stmr_pwr_t;

  typedef logic [7:0]  stmr_byte_t;
  typedef logic [15:0] stmr_word_t;

endpackage : stmr_pkg
`default_nettype wire

// ==== stmr_seq_model.sv ====
// Behavioural sequencer model that answers the command mailbox
`timescale 1ns/10ps
`default_nettype none

module stmr_seq_model #(
  parameter logic [7:0] SLEEP_CMD = 8'h0b,
  parameter logic [7:0] BAD_CMD   = 8'hff
) (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  // Command side
  input  wire logic       i_cmd_strobe,
  input  wire logic [7:0] i_cmd_code,
  input  wire logic       i_slow,
  // Answer side
  output logic            o_cmd_done,
  output logic            o_cmd_error,
  output logic      [7:0] o_err_code,
  output logic            o_seq_sleep
);
  logic [3:0] wait_cnt;
  logic [7:0] held_code;
  logic       busy;
  logic       finish;

  assign finish = busy && (wait_cnt == 4'h0);

  // ----------------------------------------------------------------------
  // Execution timer
  // ----------------------------------------------------------------------
  // Error lines churn while idle so that only done may qualify them
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      busy        <= 1'b0;
      wait_cnt    <= 4'h0;
      held_code   <= 8'h00;
      o_cmd_done  <= 1'b0;
      o_cmd_error <= 1'b0;
      o_err_code  <= 8'h00;
      o_seq_sleep <= 1'b0;
    end else begin
      o_seq_sleep <= o_cmd_done && (held_code == SLEEP_CMD);
      o_cmd_done  <= finish;
      o_cmd_error <= finish ? (held_code == BAD_CMD) : ~o_cmd_error;
      o_err_code  <= (finish && held_code == BAD_CMD) ? 8'h80 : ~o_err_code;
      if (i_cmd_strobe) begin
        busy      <= 1'b1;
        wait_cnt  <= i_slow ? 4'h5 : 4'h0;
        held_code <= i_cmd_code;
      end else if (finish) begin
        busy <= 1'b0;
      end else if (busy) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end
endmodule : stmr_seq_model
`default_nettype wire

// ==== stmr_regs_test.sv ====
// Self-checking bench for the threshold and mailbox register bank
`timescale 1ns/10ps
`default_nettype none

module stmr_regs_test import stmr_pkg::*;;
  localparam logic [7:0] SLEEP_CMD = 8'h0b;
  localparam logic [7:0] BAD_CMD   = 8'hff;
  localparam logic [7:0] PAUSE_CMD = 8'h09; // Arbitrary pause code
  logic mclk, rst, wr, rd, done, err, sleep, strobe, auton, pvalid, legacy, intr, standby, slow;
  logic [7:0]  addr, wdata, rdata, code, param, errc, resp;
  logic [15:0] presult, thr;
  logic [5:0]  irqen;
  int bad_count, samples_checked;

  stmr_regs stmr_regs_inst (.i_mclk(mclk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_cmd_strobe(strobe),
    .o_cmd_code(code), .o_param_value(param), .i_cmd_done(done), .i_cmd_error(err),
    .i_err_code(errc), .i_seq_sleep(sleep), .i_autonomous(auton), .i_ps3_valid(pvalid),
    .i_ps3_result(presult), .o_ch3_threshold(thr), .i_legacy_rev(legacy),
    .i_irq_enable(irqen), .o_int(intr), .o_standby(standby));

  stmr_seq_model #(.SLEEP_CMD(SLEEP_CMD), .BAD_CMD(BAD_CMD)) stmr_seq_model_inst (
    .i_mclk(mclk), .i_rst(rst), .i_cmd_strobe(strobe), .i_cmd_code(code), .i_slow(slow),
    .o_cmd_done(done), .o_cmd_error(err), .o_err_code(errc), .o_seq_sleep(sleep));

  // ----------------------------------------------------------------------
  // Clock, checking and closing
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------------
  // Access tasks, all driving on the falling edge
  // ----------------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask : idle

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge mclk);
    wr = 1'b0;
  endtask : wr_reg

  // Read data stands one cycle only, so it is sampled at the next fall
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    rd = 1'b1;
    addr = a;
    @(negedge mclk);
    rd = 1'b0;
    check("read data", {8'h00, rdata}, {8'h00, exp});
  endtask : rd_reg

  // Command write, then a bounded wait for the sequencer's answer
  task automatic cmd(input logic [7:0] c);
    int n;
    wr_reg(8'h18, c);
    check("command strobe", {15'h0, strobe}, 16'h0001);
    check("command code", {8'h00, code}, {8'h00, c});
    check("standby", {15'h0, standby}, 16'h0000);
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    if (n == 20) bad_count++;
    resp = (c == BAD_CMD) ? 8'h80 : {4'h0, resp[3:0] + 4'h1};
    idle(3);
  endtask : cmd

  task automatic meas(input logic [15:0] r, input logic exp_int);
    @(negedge mclk);
    pvalid = 1'b1;
    presult = r;
    @(negedge mclk);
    pvalid = 1'b0;
    idle(1);
    check("interrupt", {15'h0, intr}, {15'h0, exp_int});
  endtask : meas

  initial begin
    #125000;
    bad_count++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rst, wr, rd, auton, pvalid, legacy, slow} = 7'b1000000;
    {addr, wdata, presult, irqen, resp} = '0;
    bad_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    check("standby", {15'h0, standby}, 16'h0001);
    for (int a = 8'h15; a <= 8'h18; a++) rd_reg(a[7:0], 8'h00);
    // Accesses other than the command write leave the device asleep
    wr_reg(8'h17, 8'ha5);
    wr_reg(8'h15, 8'h3c);
    wr_reg(8'h30, 8'hff);
    rd_reg(8'h30, 8'h00);
    check("standby", {15'h0, standby}, 16'h0001);
    rd_reg(8'h17, 8'ha5);
    check("parameter", {8'h00, param}, 16'h00a5);
    wr_reg(8'h16, 8'h12);
    idle(2);
    check("threshold", thr, 16'h123c);
    rd_reg(8'h15, 8'h3c);
    rd_reg(8'h16, 8'h12);
    cmd(8'h01);
    rd_reg(8'h18, 8'h01);
    rd_reg(8'h20, resp);
    // Slow sequencer, sixteen commands so the counter wraps
    slow = 1'b1;
    for (int i = 0; i < 16; i++) cmd(8'h02);
    rd_reg(8'h20, resp);
    cmd(BAD_CMD);
    rd_reg(8'h20, 8'h80);
    cmd(8'h02);
    rd_reg(8'h20, resp);
    irqen = 6'h20;
    idle(2);
    check("interrupt", {15'h0, intr}, 16'h0001);
    wr_reg(8'h21, 8'h20);
    idle(2);
    check("interrupt", {15'h0, intr}, 16'h0000);
    // Pause before touching the threshold while measuring
    auton = 1'b1;
    irqen = 6'h10;
    cmd(PAUSE_CMD);
    wr_reg(8'h15, 8'h00);
    idle(2);
    check("threshold", thr, 16'h1200);
    wr_reg(8'h16, 8'h01);
    idle(2);
    check("threshold", thr, 16'h0100);
    meas(16'h0100, 1'b0);
    meas(16'h0101, 1'b1);
    irqen = 6'h00;
    idle(2);
    check("interrupt", {15'h0, intr}, 16'h0000);
    wr_reg(8'h21, 8'h10);
    irqen = 6'h10;
    auton = 1'b0;
    meas(16'hffff, 1'b0);
    // Older revision: compressed byte at the low offset
    legacy = 1'b1;
    idle(4);
    wr_reg(8'h15, 8'h35);
    idle(2);
    check("compressed", thr, 16'h0054);
    wr_reg(8'h15, 8'h07);
    idle(2);
    check("compressed", thr, 16'h0007);
    wr_reg(8'h15, 8'hcf);
    idle(2);
    check("compressed", thr, 16'hf800);
    legacy = 1'b0;
    // Back to sleep, then only a command write may wake
    cmd(SLEEP_CMD);
    check("standby", {15'h0, standby}, 16'h0001);
    wr_reg(8'h17, 8'h5a);
    rd_reg(8'h20, resp);
    check("standby", {15'h0, standby}, 16'h0001);
    cmd(8'h03);
    // Host load of the response byte; the next command clears its top half
    wr_reg(8'h20, 8'h4c);
    rd_reg(8'h20, 8'h4c);
    rd_reg(8'h21, 8'h20);
    resp = 8'h4c;
    cmd(8'h04);
    rd_reg(8'h20, resp);
    // Mid-run reset must clear the bytes at 0x15 to 0x18 and fall back to standby
    @(negedge mclk);
    rst = 1'b1;
    idle(2);
    rst = 1'b0;
    check("standby", {15'h0, standby}, 16'h0001);
    for (int a = 8'h15; a <= 8'h18; a++) rd_reg(a[7:0], 8'h00);
    wrap_up();
  end
endmodule : stmr_regs_test
`default_nettype wire
